// *** include/dmaq_defs.vh ***
/*
 * Constants of the DMA descriptor queue status block: register offsets, field
 * positions, reset values and sizes.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef DMAQ_DEFS_VH
`define DMAQ_DEFS_VH

// Register byte offsets
`define DMAQ_OFF_CONTROL      8'h80
`define DMAQ_OFF_STATUS       8'h84
`define DMAQ_OFF_BASE         8'h88
`define DMAQ_OFF_IRQ_STATUS   8'h90
`define DMAQ_OFF_IRQ_MASK     8'h94

// Status register fields
`define DMAQ_ST_REMAIN_MSB    31
`define DMAQ_ST_REMAIN_LSB    16
`define DMAQ_ST_COUNT_MSB     15
`define DMAQ_ST_COUNT_LSB     8
`define DMAQ_ST_OOD_BIT       6
`define DMAQ_ST_ECR_BIT       5
`define DMAQ_ST_QIDLE_BIT     4
`define DMAQ_ST_OOM_BIT       1
`define DMAQ_ST_AIDLE_BIT     0

// Control register field
`define DMAQ_CTL_ENABLE_BIT   0

// Interrupt status and mask layout
`define DMAQ_IRQ_OOD_BIT      0
`define DMAQ_IRQ_ECR_BIT      1
`define DMAQ_IRQ_OOM_BIT      2
`define DMAQ_IRQ_QIDLE_BIT    3
`define DMAQ_IRQ_W            4

// Reset values
`define DMAQ_RST_BASE         32'h00000000
`define DMAQ_RST_IRQ          4'h0
`define DMAQ_RST_COUNT        8'h00
`define DMAQ_RST_REMAIN       16'h0000

// Queue sizes
`define DMAQ_QUEUE_FULL       8'hFF
`define DMAQ_COUNT_W          8
`define DMAQ_REMAIN_W         16

// AHB encodings
`define DMAQ_HRESP_OKAY       1'b0

`endif

// *** core/dmaq_fetch.v ***
/*
 * Descriptor fetch engine: walks the descriptor linked list in host memory
 * and hands each descriptor read that completes without error to the queue.
 * Assumes a host read port that answers every request with one done pulse,
 * carrying error, size, next pointer and end-of-list flags.
 */
`timescale 1ns/1ps
`include "dmaq_defs.vh"

module dmaq_fetch #(
	parameter ADDR_W = 32
) (
	// Clock and reset
	input  wire              hclk,
	input  wire              hresetn,
	// Control from the register side
	input  wire              start,
	input  wire [ADDR_W-1:0] base_addr,
	input  wire              enable,
	input  wire              room,
	// Host descriptor read port
	output reg               rd_req_ff,
	output reg  [ADDR_W-1:0] rd_addr_ff,
	input  wire              rd_done,
	input  wire              rd_error,
	input  wire [ADDR_W-1:0] rd_next,
	input  wire              rd_eol,
	// Results
	output reg               push_ff,
	output reg               err_ff,
	output wire              busy,
	output reg               eol_ff,
	output reg               ran_ff
);

	localparam ST_IDLE = 2'd0;
	localparam ST_REQ  = 2'd1;
	localparam ST_WAIT = 2'd2;

	reg [1:0]        state_ff;
	reg [1:0]        nxt_state;
	reg [ADDR_W-1:0] next_ptr_ff;
	reg              link_ok_ff;
	wire             auto_go;

	assign busy = (state_ff != ST_IDLE);

	// Auto-load resumes the list once the queue has room again
	assign auto_go = ran_ff & link_ok_ff & ~eol_ff & room & enable;

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if ((start | auto_go) & enable & room)
					nxt_state = ST_REQ;
			end
			ST_REQ: begin
				nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (rd_done)
					nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff    <= ST_IDLE;
			rd_req_ff   <= 1'b0;
			rd_addr_ff  <= {ADDR_W{1'b0}};
			next_ptr_ff <= {ADDR_W{1'b0}};
			link_ok_ff  <= 1'b0;
			push_ff     <= 1'b0;
			err_ff      <= 1'b0;
			eol_ff      <= 1'b0;
			ran_ff      <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			push_ff   <= 1'b0;
			err_ff    <= 1'b0;
			rd_req_ff <= (nxt_state == ST_REQ);
			if (state_ff == ST_IDLE && nxt_state == ST_REQ) begin
				if (start) begin
					rd_addr_ff <= base_addr;
					eol_ff     <= 1'b0;
				end else begin
					rd_addr_ff <= next_ptr_ff;
				end
			end
			if (state_ff == ST_WAIT && rd_done) begin
				ran_ff <= 1'b1;
				if (rd_error) begin
					err_ff     <= 1'b1;
					link_ok_ff <= 1'b0;
				end else begin
					push_ff     <= 1'b1;
					eol_ff      <= rd_eol;
					next_ptr_ff <= rd_next;
					link_ok_ff  <= ~rd_eol;
				end
			end
		end
	end

endmodule

// *** core/dmaq_top.v ***
/*
 * One DMA channel's descriptor queue, application-side buffer tracking,
 * status and list-base registers, and interrupt, behind an AHB-Lite slave.
 * Assumes a single AHB master doing single word transfers, a host read port
 * for descriptors and one processing unit feeding sample words.
 */
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "dmaq_defs.vh"

module dmaq_top #(
	parameter ADDR_W  = 32,
	parameter COUNT_W = `DMAQ_COUNT_W,
	parameter SIZE_W  = `DMAQ_REMAIN_W
) (
	// Clock and reset
	input  wire              hclk,
	input  wire              hresetn,
	// AHB-Lite slave
	input  wire              hsel,
	input  wire [7:0]        haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire              hready,
	input  wire [31:0]       hwdata,
	output reg  [31:0]       hrdata,
	output reg               hreadyout,
	output reg               hresp,
	// Host descriptor read port
	output wire              desc_rd_req,
	output wire [ADDR_W-1:0] desc_rd_addr,
	input  wire              desc_rd_done,
	input  wire              desc_rd_error,
	input  wire [SIZE_W-1:0] desc_rd_size,
	input  wire [ADDR_W-1:0] desc_rd_next,
	input  wire              desc_rd_eol,
	// Processing unit side
	input  wire              app_buf_req,
	input  wire              app_word_valid,
	output reg               app_ready,
	// Interrupt
	output reg               irq
);

	localparam DEPTH = 1 << COUNT_W;

	function reg_hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			reg_hit = (addr[7:2] == offset[7:2]);
		end
	endfunction

	// Active buffer has no dwords left
	function buf_empty;
		input [SIZE_W-1:0] left;
		begin
			buf_empty = (left == `DMAQ_RST_REMAIN);
		end
	endfunction

	// Space remains after this cycle's take, or a refill lands
	function can_accept;
		input              stop;
		input              refill;
		input [SIZE_W-1:0] left;
		input              take;
		begin
			can_accept = ~stop & (refill | (left > {{(SIZE_W-1){1'b0}}, take}));
		end
	endfunction

	// Bus phase state
	reg              wr_pend_ff;
	reg [7:0]        wr_addr_ff;
	wire             addr_phase;
	wire             wr_fire;
	wire             wr_ctl;
	wire             wr_base;
	wire             wr_istat;
	wire             wr_imask;
	reg              start_pend_ff;

	// Registers
	reg              enable_ff;
	reg [ADDR_W-1:0] base_ff;
	reg [`DMAQ_IRQ_W-1:0] irq_stat_ff;
	reg [`DMAQ_IRQ_W-1:0] irq_mask_ff;
	reg [`DMAQ_IRQ_W-1:0] nxt_irq_stat;

	// Queue and application state
	reg [SIZE_W-1:0]  mem [0:DEPTH-1];
	reg [COUNT_W-1:0] wr_ptr_ff;
	reg [COUNT_W-1:0] rd_ptr_ff;
	reg [COUNT_W-1:0] count_ff;
	reg [COUNT_W-1:0] nxt_count;
	reg [SIZE_W-1:0]  remain_ff;
	reg               ood_ff;
	reg               ecr_ff;
	reg               oom_ff;
	reg               qidle_ff;
	reg               aidle_ff;

	// Fetch engine links
	wire              start_load;
	wire              room;
	wire              f_push;
	wire              f_err;
	wire              f_busy;
	wire              f_eol;
	wire              f_ran;
	wire              queue_full;
	wire              queue_empty;
	wire              pop;
	wire              push;
	wire              loadable;
	wire              word_take;
	wire              aif_need;
	wire              aif_stop;
	wire              ood_evt;
	wire              oom_evt;
	wire              nxt_qidle;
	wire [31:0]       status_word;
	reg  [31:0]       rd_mux;

	// ---------------- AHB-Lite slave ----------------
	assign addr_phase = hsel & htrans[1] & hready;
	assign wr_fire    = wr_pend_ff;
	// Per-register write strobes, valid in the data phase
	assign wr_ctl     = wr_fire & reg_hit(wr_addr_ff, `DMAQ_OFF_CONTROL);
	assign wr_base    = wr_fire & reg_hit(wr_addr_ff, `DMAQ_OFF_BASE);
	assign wr_istat   = wr_fire & reg_hit(wr_addr_ff, `DMAQ_OFF_IRQ_STATUS);
	assign wr_imask   = wr_fire & reg_hit(wr_addr_ff, `DMAQ_OFF_IRQ_MASK);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hreadyout  <= 1'b1;
			hresp      <= `DMAQ_HRESP_OKAY;
			hrdata     <= 32'h00000000;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= `DMAQ_HRESP_OKAY;
			if (hready) begin
				wr_pend_ff <= addr_phase & hwrite;
				wr_addr_ff <= haddr;
			end
			if (addr_phase & ~hwrite)
				hrdata <= rd_mux;
			else if (hready)
				hrdata <= 32'h00000000;
		end
	end

	// Status word; reserved bits read as zero
	assign status_word = {remain_ff,
	                      count_ff,
	                      1'b0, ood_ff, ecr_ff, qidle_ff,
	                      2'b00, oom_ff, aidle_ff};

	always @* begin
		rd_mux = 32'h00000000;
		if (reg_hit(haddr, `DMAQ_OFF_CONTROL))
			rd_mux[`DMAQ_CTL_ENABLE_BIT] = enable_ff;
		else if (reg_hit(haddr, `DMAQ_OFF_STATUS))
			rd_mux = status_word;
		else if (reg_hit(haddr, `DMAQ_OFF_BASE))
			rd_mux = base_ff;
		else if (reg_hit(haddr, `DMAQ_OFF_IRQ_STATUS))
			rd_mux[`DMAQ_IRQ_W-1:0] = irq_stat_ff;
		else if (reg_hit(haddr, `DMAQ_OFF_IRQ_MASK))
			rd_mux[`DMAQ_IRQ_W-1:0] = irq_mask_ff;
	end

	// ---------------- Software registers ----------------
	// Status offset has no write path at all
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_ff   <= 1'b0;
			base_ff     <= `DMAQ_RST_BASE;
			irq_mask_ff <= `DMAQ_RST_IRQ;
		end else if (wr_fire) begin
			if (wr_ctl)
				enable_ff <= hwdata[`DMAQ_CTL_ENABLE_BIT];
			if (wr_base)
				base_ff <= hwdata;
			if (wr_imask)
				irq_mask_ff <= hwdata[`DMAQ_IRQ_W-1:0];
		end
	end

	// Base write starts a load only when the queue is not full
	assign queue_full  = (count_ff == `DMAQ_QUEUE_FULL);
	assign queue_empty = (count_ff == `DMAQ_RST_COUNT);
	assign start_load  = wr_base & ~queue_full;
	// No new fetch while a pending push is about to fill the queue
	assign room        = ~queue_full & (nxt_count != `DMAQ_QUEUE_FULL);

	// Base write waits here until the fetch engine is free
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			start_pend_ff <= 1'b0;
		else if (!enable_ff)
			start_pend_ff <= 1'b0;
		else if (start_load)
			start_pend_ff <= 1'b1;
		else if (~f_busy & room)
			start_pend_ff <= 1'b0;
	end

	// ---------------- Descriptor fetch ----------------
	dmaq_fetch #(
		.ADDR_W (ADDR_W)
	) u_fetch (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.start      (start_pend_ff),
		.base_addr  (base_ff),
		.enable     (enable_ff),
		.room       (room),
		.rd_req_ff  (desc_rd_req),
		.rd_addr_ff (desc_rd_addr),
		.rd_done    (desc_rd_done),
		.rd_error   (desc_rd_error),
		.rd_next    (desc_rd_next),
		.rd_eol     (desc_rd_eol),
		.push_ff    (f_push),
		.err_ff     (f_err),
		.busy       (f_busy),
		.eol_ff     (f_eol),
		.ran_ff     (f_ran)
	);

	// Descriptor size is captured with the done pulse, pushed one cycle later
	reg [SIZE_W-1:0] size_hold_ff;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			size_hold_ff <= `DMAQ_RST_REMAIN;
		else if (desc_rd_done)
			size_hold_ff <= desc_rd_size;
	end

	// ---------------- Queue ----------------
	// A descriptor still being read counts as loadable
	assign loadable  = f_busy;
	assign push      = f_push;
	assign pop       = enable_ff & ~queue_empty & buf_empty(remain_ff);
	assign word_take = enable_ff & app_word_valid & app_ready;

	always @* begin
		nxt_count = count_ff;
		if (push & ~pop)
			nxt_count = count_ff + 1'b1;
		else if (pop & ~push)
			nxt_count = count_ff - 1'b1;
	end

	always @(posedge hclk) begin
		if (push)
			mem[wr_ptr_ff] <= size_hold_ff;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_ff <= {COUNT_W{1'b0}};
			rd_ptr_ff <= {COUNT_W{1'b0}};
			count_ff  <= `DMAQ_RST_COUNT;
			remain_ff <= `DMAQ_RST_REMAIN;
		end else begin
			count_ff <= nxt_count;
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
				remain_ff <= mem[rd_ptr_ff];
			end else if (word_take) begin
				remain_ff <= remain_ff - 1'b1;
			end
		end
	end

	// ---------------- Application side ----------------
	// Data arriving with no buffer raises out-of-descriptors when nothing is queued, pushed or loading
	assign aif_need = enable_ff & app_word_valid & buf_empty(remain_ff);
	assign aif_stop = ~enable_ff | oom_ff | ood_ff;
	assign ood_evt  = aif_need & queue_empty & ~push & ~loadable;
	assign oom_evt  = enable_ff & app_buf_req & queue_empty & ~push & ~loadable;

	// Full or end of list, and only after a load sequence ran
	assign nxt_qidle = f_ran & ~f_busy & ~push & (queue_full | f_eol);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ood_ff    <= 1'b0;
			ecr_ff    <= 1'b0;
			oom_ff    <= 1'b0;
			qidle_ff  <= 1'b0;
			aidle_ff  <= 1'b0;
			app_ready <= 1'b0;
		end else begin
			// Error flags stick until reset
			if (ood_evt)
				ood_ff <= 1'b1;
			if (f_err)
				ecr_ff <= 1'b1;
			if (oom_evt)
				oom_ff <= 1'b1;
			qidle_ff <= nxt_qidle;
			// Ready while enabled, with no out-of-memory or out-of-descriptors flag, and buffer space left after this cycle
			aidle_ff  <= can_accept(aif_stop, pop, remain_ff, word_take);
			app_ready <= can_accept(aif_stop, pop, remain_ff, word_take);
		end
	end

	// ---------------- Interrupt ----------------
	// Hardware set wins over a write-one clear in the same cycle
	always @* begin
		nxt_irq_stat = irq_stat_ff;
		if (wr_istat)
			nxt_irq_stat = irq_stat_ff & ~hwdata[`DMAQ_IRQ_W-1:0];
		if (ood_evt)
			nxt_irq_stat[`DMAQ_IRQ_OOD_BIT] = 1'b1;
		if (f_err)
			nxt_irq_stat[`DMAQ_IRQ_ECR_BIT] = 1'b1;
		if (oom_evt)
			nxt_irq_stat[`DMAQ_IRQ_OOM_BIT] = 1'b1;
		if (nxt_qidle & ~qidle_ff)
			nxt_irq_stat[`DMAQ_IRQ_QIDLE_BIT] = 1'b1;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_ff <= `DMAQ_RST_IRQ;
			irq         <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq         <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

endmodule

// *** test/dmaq_checker.sv ***
/*
 * Checker for dmaq_top: bus answers, descriptor read port and reset outputs.
 * Assumes it is bound to dmaq_top and sees one clock domain.
 */
`timescale 1ns/1ps
module dmaq_checker (
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	// Bus
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	// Descriptor port and outputs
	input wire        desc_rd_req,
	input wire        desc_rd_done,
	input wire        desc_rd_error,
	input wire        desc_rd_eol,
	input wire        app_ready,
	input wire        irq
);
	logic rd_ph_ff;
	logic outst_ff;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ph_ff <= 1'b0;
			outst_ff <= 1'b0;
		end else begin
			rd_ph_ff <= hsel & htrans[1] & hready & ~hwrite;
			outst_ff <= desc_rd_req | (outst_ff & ~desc_rd_done);
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_done;
		desc_rd_done && outst_ff;
	endsequence
	sequence s_quiet;
		!desc_rd_req [*8];
	endsequence
	AST_HRESP_OKAY: assert property (hresp == 1'b0)
		else $error("bad response");
	AST_ZERO_WAIT: assert property (hreadyout == 1'b1)
		else $error("wait state");
	AST_HRDATA_IDLE: assert property (!rd_ph_ff |-> hrdata == 32'h00000000)
		else $error("read data outside data phase");
	AST_REQ_PULSE: assert property (desc_rd_req |=> !desc_rd_req)
		else $error("request longer than one cycle");
	AST_ONE_OUTSTANDING: assert property (desc_rd_req |-> !outst_ff)
		else $error("second request outstanding");
	AST_DONE_GAP: assert property (s_done |=> !desc_rd_req)
		else $error("request too soon after done");
	AST_ERR_STOPS: assert property (s_done ##0 desc_rd_error |=> s_quiet)
		else $error("fetch after read error");
	AST_EOL_STOPS: assert property (s_done ##0 desc_rd_eol |=> s_quiet)
		else $error("fetch after end of list");
	AST_RESET_OUT: assert property ($rose(hresetn) |-> !app_ready && !irq && !desc_rd_req)
		else $error("outputs not idle after reset");
endmodule
bind dmaq_top dmaq_checker dmaq_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .desc_rd_req(desc_rd_req),
	.desc_rd_done(desc_rd_done), .desc_rd_error(desc_rd_error), .desc_rd_eol(desc_rd_eol),
	.app_ready(app_ready), .irq(irq));

// *** test/dmaq_host_model.sv ***
/*
 * Host memory model answering descriptor reads after a set latency.
 * Assumes one outstanding request; next descriptor sits 16 bytes on.
 */
`timescale 1ns/1ps
module dmaq_host_model #(
	parameter DSIZE = 16'h0004
) (
	// Clock and reset
	input  wire         hclk,
	input  wire         hresetn,
	// Descriptor read port
	input  wire         desc_rd_req,
	input  wire [31:0]  desc_rd_addr,
	output logic        desc_rd_done,
	output logic        desc_rd_error,
	output logic [15:0] desc_rd_size,
	output logic [31:0] desc_rd_next,
	output logic        desc_rd_eol,
	// Scenario control
	input  wire [7:0]   lat,
	input  wire [31:0]  err_addr,
	input  wire [31:0]  eol_addr,
	output int          n_req
);
	logic        pend_ff;
	logic [31:0] addr_ff;
	logic [7:0]  wait_ff;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_ff <= 1'b0;
			wait_ff <= 8'h00;
			addr_ff <= 32'h00000000;
			n_req <= 0;
			desc_rd_done <= 1'b0;
			desc_rd_error <= 1'b0;
			desc_rd_eol <= 1'b0;
			desc_rd_size <= 16'h0000;
			desc_rd_next <= 32'h00000000;
		end else if (pend_ff && wait_ff == 8'h00) begin
			pend_ff <= 1'b0;
			desc_rd_done <= 1'b1;
			desc_rd_error <= (addr_ff == err_addr);
			desc_rd_eol <= (addr_ff == eol_addr);
			desc_rd_size <= DSIZE;
			desc_rd_next <= addr_ff + 32'h00000010;
		end else begin
			// Released lines do not keep their last value
			desc_rd_done <= 1'b0;
			desc_rd_error <= ~desc_rd_error;
			desc_rd_eol <= ~desc_rd_eol;
			desc_rd_size <= ~desc_rd_size;
			desc_rd_next <= ~desc_rd_next;
			if (pend_ff)
				wait_ff <= wait_ff - 8'h01;
			if (desc_rd_req) begin
				pend_ff <= 1'b1;
				addr_ff <= desc_rd_addr;
				wait_ff <= lat;
				n_req <= n_req + 1;
			end
		end
	end
endmodule

// *** test/testbench.sv ***
/*
 * Self-checking bench for dmaq_top over AHB-Lite with a host memory model.
 * Assumes a 50 ns clock and that the design answers with zero wait states.
 */
`timescale 1ns/1ps
module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        app_buf_req;
	logic        app_word_valid;
	logic [7:0]  lat;
	logic [31:0] err_addr;
	logic [31:0] eol_addr;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         desc_rd_req;
	wire  [31:0] desc_rd_addr;
	wire         desc_rd_done;
	wire         desc_rd_error;
	wire  [15:0] desc_rd_size;
	wire  [31:0] desc_rd_next;
	wire         desc_rd_eol;
	wire         app_ready;
	wire         irq;
	int          n_req;
	int          fails;
	int          n_checks;
	int          cyc = 0;

	dmaq_top dmaq_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.desc_rd_req(desc_rd_req), .desc_rd_addr(desc_rd_addr), .desc_rd_done(desc_rd_done),
		.desc_rd_error(desc_rd_error), .desc_rd_size(desc_rd_size),
		.desc_rd_next(desc_rd_next), .desc_rd_eol(desc_rd_eol), .app_buf_req(app_buf_req),
		.app_word_valid(app_word_valid), .app_ready(app_ready), .irq(irq));
	dmaq_host_model dmaq_host_model_i (.hclk(hclk), .hresetn(hresetn),
		.desc_rd_req(desc_rd_req), .desc_rd_addr(desc_rd_addr), .desc_rd_done(desc_rd_done),
		.desc_rd_error(desc_rd_error), .desc_rd_size(desc_rd_size),
		.desc_rd_next(desc_rd_next), .desc_rd_eol(desc_rd_eol), .lat(lat),
		.err_addr(err_addr), .eol_addr(eol_addr), .n_req(n_req));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			end_of_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
		ahb(1'b0, a, 32'h00000000);
		chk(rd, exp, m);
	endtask

	task do_reset;
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask

	task wait_idle(input int lim);
		int k;
		k = 0;
		do begin
			ahb(1'b0, 8'h84, 32'h00000000);
			k++;
		end while (rd[4] !== 1'b1 && k < lim);
	endtask

	task send(input int n);
		int k;
		k = 0;
		app_word_valid <= 1'b1;
		while (k < n) begin
			@(posedge hclk);
			if (app_ready === 1'b1)
				k++;
		end
		app_word_valid <= 1'b0;
	endtask

	task pulse_in(input logic buf_req);
		if (buf_req)
			app_buf_req <= 1'b1;
		else
			app_word_valid <= 1'b1;
		@(posedge hclk);
		app_buf_req <= 1'b0;
		app_word_valid <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask

	task t_regs;
		rd_chk(8'h84, 32'h00000000, "status after reset");
		rd_chk(8'h88, 32'h00000000, "base after reset");
		ahb(1'b1, 8'h84, 32'hFFFFFFFF);
		rd_chk(8'h84, 32'h00000000, "status written");
		ahb(1'b1, 8'hC0, 32'hFFFFFFFF);
		rd_chk(8'hC0, 32'h00000000, "unmapped");
		ahb(1'b1, 8'h88, 32'h00002000);
		repeat (20) @(posedge hclk);
		chk(n_req, 32'h0, "fetch while disabled");
		rd_chk(8'h88, 32'h00002000, "base stored");
		$display("test regs done");
	endtask

	task t_stream;
		eol_addr = 32'h00001020;
		ahb(1'b1, 8'h80, 32'h00000001);
		ahb(1'b1, 8'h88, 32'h00001000);
		wait_idle(200);
		chk(rd, 32'h00040211, "list loaded");
		chk(desc_rd_addr, 32'h00001020, "last list address");
		send(2);
		rd_chk(8'h84, 32'h00020211, "two words taken");
		send(10);
		repeat (2) @(posedge hclk);
		rd_chk(8'h84, 32'h00000010, "drained");
		ahb(1'b1, 8'h94, 32'h00000001);
		pulse_in(1'b0);
		rd_chk(8'h84, 32'h00000050, "out of descriptors");
		chk(irq, 32'h1, "irq raised");
		rd_chk(8'h90, 32'h00000009, "irq status");
		ahb(1'b1, 8'h90, 32'h00000001);
		repeat (2) @(posedge hclk);
		chk(irq, 32'h0, "irq cleared");
		pulse_in(1'b1);
		rd_chk(8'h84, 32'h00000052, "out of memory, sticky");
		$display("test stream done");
	endtask

	task t_error;
		do_reset();
		lat = 8'h03;
		err_addr = 32'h00002010;
		ahb(1'b1, 8'h80, 32'h00000001);
		ahb(1'b1, 8'h88, 32'h00002000);
		repeat (40) @(posedge hclk);
		chk(n_req, 32'h2, "fetch stops on error");
		rd_chk(8'h84, 32'h00040021, "read error flag");
		$display("test error done");
	endtask

	task t_full;
		int k;
		do_reset();
		lat = 8'h05;
		err_addr = 32'hFFFFFFF0;
		eol_addr = 32'hFFFFFFF0;
		ahb(1'b1, 8'h80, 32'h00000001);
		ahb(1'b1, 8'h88, 32'h00000000);
		wait_idle(3000);
		chk(rd, 32'h0004FF11, "queue full");
		k = n_req;
		chk(k, 32'd256, "fetch count");
		ahb(1'b1, 8'h88, 32'h00004000);
		repeat (20) @(posedge hclk);
		chk(n_req, k, "no load when full");
		ahb(1'b1, 8'h80, 32'h00000000);
		repeat (2) @(posedge hclk);
		rd_chk(8'h84, 32'h0004FF10, "disabled, not accepting");
		chk(app_ready, 32'h0, "ready off when disabled");
		$display("test full done");
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		app_buf_req = 1'b0;
		app_word_valid = 1'b0;
		lat = 8'h00;
		err_addr = 32'hFFFFFFF0;
		eol_addr = 32'hFFFFFFF0;
		fails = 0;
		n_checks = 0;
		do_reset();
		t_regs();
		t_stream();
		t_error();
		t_full();
		end_of_test();
	end
endmodule
